// ### rtl/sar_adc_pkg.sv
package sar_adc_pkg;
   // core clock and converter clock division
   localparam int unsigned CORE_PERIOD_NS = 100;
   localparam int unsigned ADC_DIV        = 2;
   localparam int unsigned CONV_ADC_CLKS  = 12;
   localparam int unsigned STEPS          = 8;
   localparam int unsigned LOAD_ADC_CLKS  = CONV_ADC_CLKS - STEPS;
   localparam int unsigned CONV_CYCLES    = CONV_ADC_CLKS * ADC_DIV;
   // settling time after leaving halt
   localparam int unsigned STAB_TIME_NS   = 1000;
   localparam int unsigned STAB_CYCLES    =
      (STAB_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   // register map
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  RESULT_ADDR = 8'h70;
   localparam logic [7:0]  CSR_ADDR    = 8'h71;
   // control/status fields
   localparam int unsigned DONE_BIT    = 7;
   localparam int unsigned ON_BIT      = 5;
   localparam int unsigned CHAN_LSB    = 0;
   localparam int unsigned CHAN_W      = 4;
   localparam logic [7:0]  CSR_RESET   = 8'h00;
   localparam logic [7:0]  RESULT_RESET = 8'h00;
   localparam logic [7:0]  FIRST_TRIAL = 8'h80;
   // sequencer states
   typedef enum logic [1:0] {
      ST_OFF,
      ST_STAB,
      ST_LOAD,
      ST_APPROX
   } seq_state_t;
endpackage

// ### rtl/sar_adc_sequencer.sv
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module sar_adc_sequencer (
   input  wire logic                             i_core_clk,
   input  wire logic                             i_rst_n,
   input  wire logic                             i_clk_en,
   input  wire logic [sar_adc_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [7:0]                       i_wdata,
   input  wire logic                             i_wr,
   input  wire logic                             i_rd,
   output logic      [7:0]                       o_rdata,
   input  wire logic                             i_halt_mode,
   input  wire logic                             i_comp_ge,
   output logic      [sar_adc_pkg::CHAN_W-1:0]   o_mux_select,
   output logic                                  o_sample_connect,
   output logic      [7:0]                       o_dac_code,
   output logic                                  o_converter_powered
);
   typedef struct packed {
      sar_adc_pkg::seq_state_t          state;
      logic                             phase;
      logic [3:0]                       count;
      logic [7:0]                       mask;
      logic [7:0]                       trial;
      logic [7:0]                       result;
      logic                             done;
      logic                             on;
      logic [sar_adc_pkg::CHAN_W-1:0]   chan;
      logic [7:0]                       rdata;
      logic                             sample;
      logic                             powered;
      logic                             stab_pend;
      logic [7:0]                       stab;
   } regs_t;

   localparam regs_t REGS_RESET = '{state: sar_adc_pkg::ST_OFF, default: '0};
   localparam logic [3:0] LOAD_LAST =
      4'(sar_adc_pkg::LOAD_ADC_CLKS - 1);
   localparam logic [7:0] STAB_LAST =
      8'(sar_adc_pkg::STAB_CYCLES - 1);

   regs_t      r;
   regs_t      next_r;
   logic       finish;
   logic       csr_wr;
   logic       res_rd;
   logic [7:0] decided;

   // bus decode
   assign csr_wr = i_wr && (i_addr == sar_adc_pkg::CSR_ADDR);
   assign res_rd = i_rd && (i_addr == sar_adc_pkg::RESULT_ADDR);

   // sequencer, register access and power modes
   always_comb begin
      next_r  = r;
      finish  = 1'b0;
      decided = r.trial;
      next_r.rdata = 8'h00;
      // converter clock: action on every second core cycle
      if (r.state == sar_adc_pkg::ST_OFF) begin
         next_r.phase = 1'b0;
      end else begin
         next_r.phase = ~r.phase;
      end
      // no wait mode input: the sequencer runs on regardless
      case (r.state)
         sar_adc_pkg::ST_OFF: begin
            next_r.sample = 1'b0;
            if (r.on) begin
               next_r.powered = 1'b1;
               next_r.count   = 4'h0;
               next_r.stab    = 8'h00;
               if (r.stab_pend) begin
                  next_r.state = sar_adc_pkg::ST_STAB;
               end else begin
                  next_r.state  = sar_adc_pkg::ST_LOAD;
                  next_r.sample = 1'b1;
               end
            end
         end
         sar_adc_pkg::ST_STAB: begin
            next_r.stab = r.stab + 8'h01;
            if (r.stab == STAB_LAST) begin
               next_r.stab_pend = 1'b0;
               next_r.state     = sar_adc_pkg::ST_LOAD;
               next_r.phase     = 1'b0;
               next_r.sample    = 1'b1;
            end
         end
         sar_adc_pkg::ST_LOAD: begin
            next_r.sample = 1'b1;
            if (r.phase) begin
               next_r.count = r.count + 4'h1;
               if (r.count == LOAD_LAST) begin
                  next_r.state  = sar_adc_pkg::ST_APPROX;
                  next_r.sample = 1'b0;
                  next_r.mask   = sar_adc_pkg::FIRST_TRIAL;
                  next_r.trial  = sar_adc_pkg::FIRST_TRIAL;
               end
            end
         end
         sar_adc_pkg::ST_APPROX: begin
            next_r.sample = 1'b0;
            if (r.phase) begin
               // keep the bit when input is at or above the trial
               if (!i_comp_ge) begin
                  decided = r.trial & ~r.mask;
               end
               // plain bitwise or of the next lower bit, so the code stays in 00 to ff with no overflow
               next_r.trial = decided | (r.mask >> 1);
               next_r.mask  = r.mask >> 1;
               if (r.mask[0]) begin
                  finish        = 1'b1;
                  next_r.result = decided;
                  next_r.done   = 1'b1;
                  next_r.trial  = decided;
                  next_r.state  = sar_adc_pkg::ST_LOAD;
                  next_r.count  = 4'h0;
                  next_r.sample = 1'b1;
               end
            end
         end
         default: begin
            next_r.state = sar_adc_pkg::ST_OFF;
         end
      endcase
      // reads: result read clears done unless set this cycle
      if (i_rd) begin
         if (i_addr == sar_adc_pkg::RESULT_ADDR) begin
            next_r.rdata = r.result;
         end else if (i_addr == sar_adc_pkg::CSR_ADDR) begin
            next_r.rdata = {r.done, 1'b0, r.on, 1'b0, r.chan};
         end
      end
      if (res_rd && !finish) begin
         next_r.done = 1'b0;
      end
      // control write clears done and restarts or stops
      if (csr_wr) begin
         next_r.done  = 1'b0;
         next_r.on    = i_wdata[sar_adc_pkg::ON_BIT];
         next_r.chan  = i_wdata[sar_adc_pkg::CHAN_LSB +:
                                sar_adc_pkg::CHAN_W];
         next_r.phase = 1'b0;
         next_r.count = 4'h0;
         // a pending settle delay is never cut short by a write
         if (i_wdata[sar_adc_pkg::ON_BIT]) begin
            if (!r.stab_pend) begin
               next_r.state   = sar_adc_pkg::ST_LOAD;
               next_r.sample  = 1'b1;
               next_r.powered = 1'b1;
            end
         end else begin
            next_r.state   = sar_adc_pkg::ST_OFF;
            next_r.sample  = 1'b0;
            next_r.powered = 1'b0;
         end
      end
      // halt powers the converter down and arms the settle delay
      if (i_halt_mode) begin
         next_r.state     = sar_adc_pkg::ST_OFF;
         next_r.phase     = 1'b0;
         next_r.sample    = 1'b0;
         next_r.powered   = 1'b0;
         next_r.stab_pend = 1'b1;
      end
   end

   // state register with clock enable
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         r <= REGS_RESET;
      end else if (i_clk_en) begin
         r <= next_r;
      end
   end

   assign o_rdata             = r.rdata;
   assign o_mux_select        = r.chan;
   assign o_sample_connect    = r.sample;
   assign o_dac_code          = r.trial;
   assign o_converter_powered = r.powered;

   // cycles since the current conversion started loading
   logic [4:0] conv_age;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         conv_age <= 5'h00;
      end else if (i_clk_en) begin
         if (next_r.state == sar_adc_pkg::ST_LOAD &&
             (r.state != sar_adc_pkg::ST_LOAD || csr_wr)) begin
            conv_age <= 5'h00;
         end else begin
            conv_age <= conv_age + 5'h01;
         end
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_finish;
      finish && i_clk_en;
   endsequence
   sequence s_restart;
      r.state == sar_adc_pkg::ST_LOAD && r.count == 4'h0 && !r.phase;
   endsequence

   a_conv_length: assert property (
      s_finish |-> conv_age == 5'(sar_adc_pkg::CONV_CYCLES - 1))
      else $error("conversion not twelve converter clocks");
   a_result_flag: assert property (
      (s_finish and !csr_wr) |=> r.done && r.result == $past(decided))
      else $error("result and done flag not set together");
   a_loop_back: assert property (
      (s_finish and (!csr_wr && !i_halt_mode)) |=>
         s_restart ##0 (r.sample && r.done))
      else $error("no return to sample loading");
   a_msb_first: assert property (
      $rose(r.state == sar_adc_pkg::ST_APPROX) |->
         r.trial == sar_adc_pkg::FIRST_TRIAL && !o_sample_connect)
      else $error("approximation does not start at msb");
   a_cap_open: assert property (
      r.state == sar_adc_pkg::ST_APPROX |-> !o_sample_connect)
      else $error("capacitor connected while approximating");
   a_write_abort: assert property (
      csr_wr && i_clk_en && i_wdata[sar_adc_pkg::ON_BIT] &&
      !i_halt_mode && !r.stab_pend |=> s_restart ##0 !r.done)
      else $error("control write did not restart");
   a_read_clear: assert property (
      res_rd && i_clk_en && !finish |=> !r.done)
      else $error("result read did not clear done");
   a_off_idle: assert property (
      csr_wr && i_clk_en && !i_wdata[sar_adc_pkg::ON_BIT] |=>
         !o_converter_powered && !o_sample_connect)
      else $error("converter still running when off");
   a_halt_off: assert property (
      i_halt_mode && i_clk_en |=> r.state == sar_adc_pkg::ST_OFF
         ##1 (r.state != sar_adc_pkg::ST_LOAD))
      else $error("halt did not stop the converter");
   a_reset_clear: assert property (
      @(posedge i_core_clk) disable iff (1'b0)
      !i_rst_n |=> r.state == sar_adc_pkg::ST_OFF
         && !r.on && !r.done && r.chan == 4'h0 && r.result == 8'h00)
      else $error("reset left converter state");

   // register side: flag clearing, channel field, result holding
   a_write_clear: assert property (
      csr_wr && i_clk_en |=> !r.done)
      else $error("control write did not clear done");
   a_mux_follows: assert property (
      csr_wr && i_clk_en |=> o_mux_select ==
         $past(i_wdata[sar_adc_pkg::CHAN_LSB +: sar_adc_pkg::CHAN_W]))
      else $error("channel select does not follow the field");
   a_result_hold: assert property (
      !(finish && i_clk_en) |=> $stable(r.result))
      else $error("result changed without a finished conversion");
   a_done_source: assert property (
      $rose(r.done) |-> $past(finish && i_clk_en))
      else $error("done flag set without a finished conversion");

   // converter side: settle, load length, trial mask, idle outputs
   a_settle_gate: assert property (
      r.state == sar_adc_pkg::ST_STAB |->
         o_converter_powered && !o_sample_connect)
      else $error("sampling during the settle delay");
   a_settle_exit: assert property (
      r.state == sar_adc_pkg::ST_STAB && r.stab == STAB_LAST &&
      i_clk_en && !csr_wr && !i_halt_mode |=> s_restart ##0 r.sample)
      else $error("settle delay did not end in sample loading");
   a_mask_onehot: assert property (
      r.state == sar_adc_pkg::ST_APPROX |-> $onehot(r.mask))
      else $error("not exactly one trial bit in play");
   a_off_quiet: assert property (
      r.state == sar_adc_pkg::ST_OFF |->
         !o_sample_connect && !o_converter_powered)
      else $error("converter active while off");
   a_load_bound: assert property (
      r.state == sar_adc_pkg::ST_LOAD |-> r.count <= LOAD_LAST)
      else $error("sample loading ran past its length");
   a_rdata_idle: assert property (
      !i_rd && i_clk_en |=> o_rdata == 8'h00)
      else $error("read data not zero between reads");
endmodule

// ### testbench/analog_model.sv
`timescale 1ns/1ps
module analog_model (
   input  wire logic [15:0][7:0] i_levels,
   input  wire logic [3:0]       i_mux_select,
   input  wire logic [7:0]       i_dac_code,
   output logic                  o_comp_ge
);
   // comparator: level of the selected input against the trial code
   assign o_comp_ge = (i_levels[i_mux_select] >= i_dac_code);
endmodule

// ### testbench/tb_sar_adc_sequencer.sv
`timescale 1ns/1ps
module tb_sar_adc_sequencer;
   typedef struct packed {
      logic [3:0] ch;
      logic [7:0] lv;
   } row_t;
   logic            i_core_clk;
   logic            i_rst_n;
   logic            i_clk_en;
   logic [7:0]      i_addr;
   logic [7:0]      i_wdata;
   logic            i_wr;
   logic            i_rd;
   logic            i_halt_mode;
   logic [7:0]      o_rdata;
   logic            comp_ge;
   logic [3:0]      o_mux_select;
   logic            o_sample_connect;
   logic [7:0]      o_dac_code;
   logic            o_converter_powered;
   logic [15:0][7:0] levels;
   int              n_errors;
   int              compares;
   int              cycles;
   int              n;
   logic [7:0]      d;
   row_t            rows [8] = '{'{4'h0, 8'h00}, '{4'hf, 8'hff},
      '{4'h3, 8'h7f}, '{4'h3, 8'h80}, '{4'h9, 8'h01}, '{4'h9, 8'hfe},
      '{4'h5, 8'h55}, '{4'hc, 8'haa}};
   localparam logic [7:0] CA = sar_adc_pkg::CSR_ADDR;
   localparam logic [7:0] RA = sar_adc_pkg::RESULT_ADDR;

   sar_adc_sequencer sar_adc_sequencer_inst (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_halt_mode(i_halt_mode), .i_comp_ge(comp_ge),
      .o_mux_select(o_mux_select), .o_sample_connect(o_sample_connect),
      .o_dac_code(o_dac_code), .o_converter_powered(o_converter_powered));
   analog_model analog_model_inst (.i_levels(levels),
      .i_mux_select(o_mux_select), .i_dac_code(o_dac_code),
      .o_comp_ge(comp_ge));

   // clock and cycle ceiling
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one-cycle bus strobes, changed right after the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_core_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_core_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic wait_done();
      d = 8'h00;
      for (int k = 0; k < 60 && d[7] !== 1'b1; k++) rd(CA, d);
      chk("done", 8'h80, d & 8'h80);
   endtask
   task automatic run_len(input logic lvl);
      n = 0;
      while (o_sample_connect === lvl && n < 60) begin
         @(posedge i_core_clk);
         #1 n++;
      end
   endtask

   initial begin
      i_rst_n = 1'b0; i_clk_en = 1'b1; i_addr = 8'h00; i_wdata = 8'h00;
      i_wr = 1'b0; i_rd = 1'b0; i_halt_mode = 1'b0;
      for (int i = 0; i < 16; i++) levels[i] = 8'(i * 16);
      repeat (20) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      rd(CA, d); chk("csr reset", 8'h00, d);
      rd(RA, d); chk("result reset", 8'h00, d);
      chk("powered", 8'h00, {7'h0, o_converter_powered});
      rd(8'h72, d); chk("unmapped", 8'h00, d);
      // table of channel and level pairs
      foreach (rows[i]) begin
         levels[rows[i].ch] <= rows[i].lv;
         wr(CA, {4'h2, rows[i].ch});
         wait_done();
         chk("mux", {4'h0, rows[i].ch}, {4'h0, o_mux_select});
         rd(RA, d); chk("result", rows[i].lv, d);
         rd(CA, d); chk("csr", {4'h2, rows[i].ch}, d);
      end
      // phase lengths of one conversion
      levels[2] <= 8'h3c;
      wr(CA, 8'h22);
      #1 run_len(1'b1); chk("load", 8'h08, 8'(n));
      run_len(1'b0); chk("approx", 8'h10, 8'(n));
      chk("dac", 8'h3c, o_dac_code);
      rd(CA, d); chk("done", 8'ha2, d);
      wr(RA, 8'h11); rd(RA, d); chk("ro", 8'h3c, d);
      // abort in mid conversion with another channel
      wait_done(); repeat (12) @(posedge i_core_clk);
      levels[7] <= 8'hc3;
      wr(CA, 8'h27); repeat (10) @(posedge i_core_clk);
      rd(CA, d); chk("abort", 8'h27, d);
      wait_done(); rd(RA, d); chk("abort res", 8'hc3, d);
      // ignored access with clock enable low
      @(posedge i_core_clk); i_clk_en <= 1'b0;
      wr(CA, 8'h00); @(posedge i_core_clk); i_clk_en <= 1'b1;
      rd(CA, d); chk("clk_en", 8'h27, d & 8'h7f);
      // halt forces off, then a settled conversion follows
      @(posedge i_core_clk); i_halt_mode <= 1'b1;
      repeat (30) @(posedge i_core_clk);
      chk("halt pwr", 8'h00, {7'h0, o_converter_powered});
      chk("halt smp", 8'h00, {7'h0, o_sample_connect});
      i_halt_mode <= 1'b0; repeat (5) @(posedge i_core_clk); #1;
      d = {6'h0, o_converter_powered, o_sample_connect};
      chk("settle", 8'h02, d);
      rd(RA, d); wait_done(); rd(RA, d); chk("wake", 8'hc3, d);
      // switching off stops conversions
      wr(CA, 8'h07); repeat (60) @(posedge i_core_clk); #1;
      chk("off pwr", 8'h00, {7'h0, o_converter_powered});
      chk("off smp", 8'h00, {7'h0, o_sample_connect});
      rd(CA, d); chk("off csr", 8'h07, d);
      // switching on after a halt still waits for the settle delay
      @(posedge i_core_clk); i_halt_mode <= 1'b1;
      @(posedge i_core_clk); i_halt_mode <= 1'b0;
      wr(CA, 8'h27); repeat (3) @(posedge i_core_clk); #1;
      d = {6'h0, o_converter_powered, o_sample_connect};
      chk("late on", 8'h02, d);
      wait_done(); rd(RA, d); chk("late res", 8'hc3, d);
      i_rst_n <= 1'b0; repeat (2) @(posedge i_core_clk); i_rst_n <= 1'b1;
      rd(CA, d); chk("rerst", 8'h00, d);
      finish_test();
   end
endmodule
